// [design/dwrp_pair_buf.v]
`default_nettype none

module dwrp_pair_buf #(
    parameter WIDTH = 33,
    parameter DEPTH = 2
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    // Entry 0 is always the head, so the output comes straight from a flop
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [DEPTH:0] cnt;
    reg full;
    reg nempty;
    wire push;
    wire pop;
    reg [DEPTH:0] next_cnt;
    integer i;

    assign in_ready = ~full;
    assign out_valid = nempty;
    assign out_data = mem[0];
    assign push = in_valid & ~full;
    assign pop = out_ready & nempty;

    always @* begin
        next_cnt = cnt;
        if (push & ~pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop & ~push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= {(DEPTH+1){1'b0}};
            full <= 1'b0;
            nempty <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else begin
            cnt <= next_cnt;
            full <= (next_cnt == DEPTH);
            nempty <= (next_cnt != 0);
            for (i = 0; i < DEPTH; i = i + 1) begin
                if (pop) begin
                    if (push && (i == cnt - 1)) begin
                        mem[i] <= in_data;
                    end else if (i < DEPTH - 1) begin
                        mem[i] <= mem[i+1];
                    end
                end else if (push && (i == cnt)) begin
                    mem[i] <= in_data;
                end
            end
        end
    end

endmodule // dwrp_pair_buf

`default_nettype wire

// [design/dwrp_prefetch_ctrl.v]
`default_nettype none
`include "dwrp_regs.vh"

module dwrp_prefetch_ctrl #(
    parameter ADDR_WIDTH = 32,
    parameter LINE_SHIFT = 6,
    parameter QDEPTH = 4
) (
    input wire clk,
    input wire rst_n,
    input wire warm_reset,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire req_valid,
    output reg req_ready,
    input wire [ADDR_WIDTH-1:0] req_addr,
    input wire [1:0] req_cmd,
    output wire up_valid,
    input wire up_ready,
    output wire [ADDR_WIDTH-1:0] up_addr,
    output wire up_single,
    input wire up_line_ok,
    input wire pci_attempt,
    input wire pci_line_taken,
    input wire pci_done,
    output reg pci_retry,
    output reg pci_reconnect
);

    localparam ST_IDLE = 1'b0;
    localparam ST_ACTIVE = 1'b1;
    localparam QPW = 2;

    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] be;
        integer k;
        begin
            be_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    be_merge[k*8 +: 8] = wd[k*8 +: 8];
                end
            end
        end
    endfunction

    // Lines wanted for a fixed prefetch: count plus the first line
    function [7:0] total_lines;
        input [2:0] cnt;
        begin
            total_lines = {5'b0_0000, cnt} + 8'h01;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    reg [`DWRP_RC_WIDTH-1:0] rc1;
    reg [`DWRP_RC_WIDTH-1:0] rc2;
    reg [31:0] win_base;
    reg [31:0] win_limit;
    reg [1:0] mode;
    reg bus_ack;
    wire generic;
    wire [31:0] rc2_merged;
    wire [31:0] rc1_merged;

    assign generic = (mode == `DWRP_MODE_GENERIC_SLAVE) || (mode == `DWRP_MODE_GENERIC_DEVICE);
    assign rc2_merged = be_merge({8'h00, rc2}, avs_writedata, avs_byteenable);
    assign rc1_merged = be_merge({8'h00, rc1}, avs_writedata, avs_byteenable);

    reg state;
    reg [2:0] out_cnt;
    reg hit_last;
    reg [7:0] arrived;
    reg [7:0] init_need;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            // One wait cycle, then a single-cycle answer
            bus_ack <= (avs_read | avs_write) & ~bus_ack;
            avs_waitrequest <= ~((avs_read | avs_write) & ~bus_ack);
            if (avs_read & ~bus_ack) begin
                case (avs_address)
                    `DWRP_OFS_WIN_BASE: avs_readdata <= win_base;
                    `DWRP_OFS_WIN_LIMIT: avs_readdata <= win_limit;
                    `DWRP_OFS_MODE: avs_readdata <= {30'h0000_0000, mode};
                    `DWRP_OFS_STATUS: avs_readdata <= {26'h000_0000, hit_last, (arrived >= init_need), state, out_cnt};
                    `DWRP_OFS_RC2: avs_readdata <= generic ? {8'h00, rc2} : 32'h0000_0000;
                    `DWRP_OFS_RC1: avs_readdata <= {8'h00, rc1};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rc1 <= `DWRP_RC_RESET;
            rc2 <= `DWRP_RC_RESET;
            win_base <= `DWRP_WIN_BASE_RESET;
            win_limit <= `DWRP_WIN_LIMIT_RESET;
            mode <= `DWRP_MODE_RESET;
        end else if (warm_reset) begin
            rc1 <= `DWRP_RC_RESET;
            rc2 <= `DWRP_RC_RESET;
        end else if (bus_ack & avs_write) begin
            case (avs_address)
                `DWRP_OFS_WIN_BASE: win_base <= be_merge(win_base, avs_writedata, avs_byteenable);
                `DWRP_OFS_WIN_LIMIT: win_limit <= be_merge(win_limit, avs_writedata, avs_byteenable);
                `DWRP_OFS_MODE: mode <= avs_byteenable[0] ? avs_writedata[1:0] : mode;
                `DWRP_OFS_RC2: begin
                    if (generic) begin
                        rc2 <= rc2_merged[`DWRP_RC_WIDTH-1:0] & `DWRP_RC_WMASK;
                    end
                end
                `DWRP_OFS_RC1: rc1 <= rc1_merged[`DWRP_RC_WIDTH-1:0] & `DWRP_RC_WMASK;
                default: rc1 <= rc1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delayed request queue

    reg [ADDR_WIDTH-1:0] q_addr [0:QDEPTH-1];
    reg [1:0] q_cmd [0:QDEPTH-1];
    reg [QPW-1:0] q_head;
    reg [QPW-1:0] q_tail;
    reg [2:0] q_cnt;
    wire accept;
    wire start;
    wire finish;
    reg [2:0] next_out_cnt;
    wire [2:0] dly_limit;

    // Limit comes from the primary register; the queue holds the maximum of four
    // field plus one
    assign dly_limit = {1'b0, rc1[`DWRP_F_DLY_REQ +: 2]} + 3'b001;
    assign accept = req_valid & req_ready;
    assign start = (state == ST_IDLE) && (q_cnt != 3'b000);
    assign finish = (state == ST_ACTIVE) && pci_done;

    always @* begin
        next_out_cnt = out_cnt;
        if (accept & ~finish) begin
            next_out_cnt = out_cnt + 3'b001;
        end else if (finish & ~accept) begin
            next_out_cnt = out_cnt - 3'b001;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_head <= {QPW{1'b0}};
            q_tail <= {QPW{1'b0}};
            q_cnt <= 3'b000;
            out_cnt <= 3'b000;
            req_ready <= 1'b0;
        end else begin
            out_cnt <= next_out_cnt;
            req_ready <= (next_out_cnt < dly_limit);
            if (accept) begin
                q_tail <= q_tail + 1'b1;
            end
            if (start) begin
                q_head <= q_head + 1'b1;
            end
            if (accept & ~start) begin
                q_cnt <= q_cnt + 3'b001;
            end else if (start & ~accept) begin
                q_cnt <= q_cnt - 3'b001;
            end
        end
    end

    always @(posedge clk) begin
        if (accept) begin
            q_addr[q_tail] <= req_addr;
            q_cmd[q_tail] <= req_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prefetch settings for the request at the queue head

    wire [ADDR_WIDTH-1:0] h_addr;
    wire [1:0] h_cmd;
    wire in_win;
    wire [`DWRP_RC_WIDTH-1:0] sel;
    wire is_mult;
    wire pf_ok;
    wire [2:0] s_cnt;
    wire [2:0] s_init;
    wire s_cont;
    wire [7:0] s_total;
    wire [7:0] s_init_lines;

    assign h_addr = q_addr[q_head];
    assign h_cmd = q_cmd[q_head];
    assign in_win = generic && (h_addr >= win_base[ADDR_WIDTH-1:0]) && (h_addr <= win_limit[ADDR_WIDTH-1:0]);
    // window hits use the alternate register
    assign sel = in_win ? rc2 : rc1;
    assign is_mult = (h_cmd == `DWRP_CMD_MULT);
    // plain reads prefetch only when enabled
    assign pf_ok = sel[`DWRP_B_PF_EN] &&
                   (is_mult || (h_cmd == `DWRP_CMD_LINE) || (h_cmd == `DWRP_CMD_PLAIN && sel[`DWRP_B_PLAIN_PF]));
    assign s_cnt = is_mult ? sel[`DWRP_F_MULT_CNT +: 3] : sel[`DWRP_F_LINE_CNT +: 3];
    assign s_init = is_mult ? sel[`DWRP_F_MULT_INIT +: 3] : sel[`DWRP_F_LINE_INIT +: 3];
    assign s_cont = pf_ok && (is_mult ? sel[`DWRP_B_MULT_CONT] : sel[`DWRP_B_LINE_CONT]);
    assign s_total = pf_ok ? total_lines(s_cnt) : 8'h01;
    // Initial count is at least one line and, when not continuous, never beyond the fixed total
    assign s_init_lines = !pf_ok ? 8'h01 :
                          (s_init == 3'b000) ? 8'h01 :
                          (!s_cont && ({5'b0_0000, s_init} > s_total)) ? s_total : {5'b0_0000, s_init};

    ////////////////////////////////////////////////////////////////////////////
    // Fetch engine

    reg [ADDR_WIDTH-1:0] line_base;
    reg [7:0] total;
    reg [7:0] issued;
    reg single;
    reg cont;
    wire issue;
    wire buf_ready;
    wire [ADDR_WIDTH-1:0] fetch_addr;
    wire [ADDR_WIDTH-1:0] issued_ofs;

    assign issued_ofs = {{(ADDR_WIDTH-8){1'b0}}, issued} << LINE_SHIFT;
    assign fetch_addr = single ? line_base : line_base + issued_ofs;
    assign issue = (state == ST_ACTIVE) && (issued < total) && buf_ready;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            line_base <= {ADDR_WIDTH{1'b0}};
            total <= 8'h00;
            issued <= 8'h00;
            arrived <= 8'h00;
            init_need <= 8'h01;
            single <= 1'b0;
            cont <= 1'b0;
            hit_last <= 1'b0;
            pci_retry <= 1'b0;
            pci_reconnect <= 1'b0;
        end else begin
            pci_retry <= 1'b0;
            pci_reconnect <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_ACTIVE;
                        // Non-prefetched reads of any command, line reads included, keep the word address
                        single <= ~pf_ok;
                        line_base <= pf_ok ? ((h_addr >> LINE_SHIFT) << LINE_SHIFT) : h_addr;
                        total <= s_total;
                        init_need <= s_init_lines;
                        cont <= s_cont;
                        hit_last <= in_win;
                        issued <= 8'h00;
                        arrived <= 8'h00;
                    end
                    if (pci_attempt) begin
                        pci_retry <= 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (issue) begin
                        issued <= issued + 8'h01;
                    end
                    // moving window, one line per delivered line
                    if (cont && pci_line_taken && (total != 8'hff)) begin
                        total <= total + 8'h01;
                    end
                    if (up_line_ok && (arrived != 8'hff)) begin
                        arrived <= arrived + 8'h01;
                    end
                    if (pci_attempt) begin
                        pci_reconnect <= (arrived >= init_need);
                        pci_retry <= (arrived < init_need);
                    end
                    if (pci_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Upstream fetch requests, decoupled so an upstream stall loses nothing

    dwrp_pair_buf #(
        .WIDTH(ADDR_WIDTH + 1),
        .DEPTH(2)
    ) u_fetch_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(issue),
        .in_ready(buf_ready),
        .in_data({single, fetch_addr}),
        .out_valid(up_valid),
        .out_ready(up_ready),
        .out_data({up_single, up_addr})
    );

endmodule // dwrp_prefetch_ctrl

`default_nettype wire

// [design/dwrp_regs.vh]
`ifndef DWRP_REGS_VH
`define DWRP_REGS_VH

// Register byte addresses
`define DWRP_OFS_WIN_BASE 8'h40
`define DWRP_OFS_WIN_LIMIT 8'h44
`define DWRP_OFS_MODE 8'h48
`define DWRP_OFS_STATUS 8'h4c
`define DWRP_OFS_RC2 8'h5c
`define DWRP_OFS_RC1 8'h60

// Read control layout, shared by both read control registers
`define DWRP_RC_WIDTH 24
`define DWRP_RC_RESET 24'h00_0001
`define DWRP_RC_WMASK 24'h3f_ffff
`define DWRP_F_LINE_INIT 19
`define DWRP_F_MULT_INIT 16
`define DWRP_B_LINE_CONT 11
`define DWRP_B_MULT_CONT 10
`define DWRP_F_DLY_REQ 8
`define DWRP_F_LINE_CNT 5
`define DWRP_F_MULT_CNT 2
`define DWRP_B_PLAIN_PF 1
`define DWRP_B_PF_EN 0

// Operating modes
`define DWRP_MODE_PLAIN_SLAVE 2'b00
`define DWRP_MODE_GENERIC_SLAVE 2'b01
`define DWRP_MODE_GENERIC_DEVICE 2'b10
`define DWRP_MODE_RESET 2'b00

// Read commands
`define DWRP_CMD_PLAIN 2'b00
`define DWRP_CMD_LINE 2'b01
`define DWRP_CMD_MULT 2'b10

`define DWRP_WIN_BASE_RESET 32'h0000_0000
`define DWRP_WIN_LIMIT_RESET 32'h0000_0000

`endif

// [test/dwrp_mem_model.sv]
`default_nettype none
module dwrp_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic give,
    input wire logic clr,
    input wire logic up_valid,
    input wire logic [31:0] up_addr,
    input wire logic up_single,
    output logic up_ready,
    output logic up_line_ok,
    output logic [7:0] nlines,
    output logic [31:0] first_addr,
    output logic first_single,
    output logic [7:0] bad
);
    logic tog;
    logic [31:0] last;
    // Stall every other cycle so the buffer must hold words
    assign up_ready = !(stall && tog);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog <= 1'b0;
            up_line_ok <= 1'b0;
            nlines <= 8'h00;
            bad <= 8'h00;
            first_addr <= 32'h0000_0000;
            first_single <= 1'b0;
            last <= 32'h0000_0000;
        end else begin
            tog <= !tog;
            up_line_ok <= give;
            if (clr) begin
                nlines <= 8'h00;
            end else if (up_valid && up_ready) begin
                nlines <= nlines + 8'h01;
                last <= up_addr;
                if (nlines == 8'h00) begin
                    first_addr <= up_addr;
                    first_single <= up_single;
                end else if (up_addr != last + 32'h0000_0040) begin
                    bad <= bad + 8'h01;
                end
            end
        end
    end
endmodule // dwrp_mem_model
`default_nettype wire

// [test/dwrp_prefetch_ctrl_monitor.sv]
`default_nettype none
`include "dwrp_regs.vh"
module dwrp_prefetch_ctrl_monitor #(
    parameter ADDR_WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic warm_reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [ADDR_WIDTH-1:0] req_addr,
    input wire logic [1:0] req_cmd,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire logic [ADDR_WIDTH-1:0] up_addr,
    input wire logic up_single,
    input wire logic up_line_ok,
    input wire logic pci_attempt,
    input wire logic pci_line_taken,
    input wire logic pci_done,
    input wire logic pci_retry,
    input wire logic pci_reconnect
);
    logic [1:0] lim;
    logic [1:0] mode;
    logic [2:0] outst;
    wire wr_ack = avs_write && !avs_waitrequest;
    wire rd_ack = avs_read && !avs_waitrequest;
    // Shadow of limit and mode, taken at the write's answer edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lim <= 2'h0;
            mode <= `DWRP_MODE_RESET;
            outst <= 3'h0;
        end else begin
            if (warm_reset)
                lim <= 2'h0;
            else if (wr_ack && avs_address == `DWRP_OFS_RC1 && avs_byteenable[1])
                lim <= avs_writedata[9:8];
            if (wr_ack && avs_address == `DWRP_OFS_MODE && avs_byteenable[0])
                mode <= avs_writedata[1:0];
            outst <= outst + 3'(req_valid && req_ready) - 3'(pci_done && outst != 3'h0);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    chk_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_reply_one: assert property (pci_attempt |=> pci_retry != pci_reconnect)
        else $error("attempt not answered by exactly one of retry and reconnect");
    chk_reply_cause: assert property (!pci_attempt |=> !pci_retry && !pci_reconnect)
        else $error("retry or reconnect without an attempt");
    chk_up_hold: assert property (up_valid && !up_ready |=> up_valid && $stable(up_addr) && $stable(up_single))
        else $error("upstream request changed while stalled");
    chk_req_limit: assert property (req_ready |-> outst <= {1'b0, lim})
        else $error("request accepted beyond the delayed request limit");
    chk_rc2_hidden: assert property (rd_ack && avs_address == `DWRP_OFS_RC2 && (mode == 2'h0 || mode == 2'h3)
        |-> avs_readdata == 32'h0000_0000)
        else $error("alternate read control visible in plain slave mode");
    chk_rc_top: assert property (rd_ack && (avs_address == `DWRP_OFS_RC1 || avs_address == `DWRP_OFS_RC2)
        |-> avs_readdata[31:22] == 10'h000)
        else $error("read control reserved bits not zero");
    chk_unmapped_zero: assert property (rd_ack && avs_address == 8'h50 |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped address read not zero");
endmodule // dwrp_prefetch_ctrl_monitor
`default_nettype wire

// [test/dwrp_prefetch_ctrl_tb_top.sv]
`default_nettype none
`include "dwrp_regs.vh"
module dwrp_prefetch_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] mode;
        logic [23:0] rc1;
        logic [23:0] rc2;
        logic [1:0] cmd;
        logic [31:0] addr;
        logic [2:0] need;
        logic [7:0] lines;
        logic ext;
        logic single;
    } dwrp_row_t;
    dwrp_row_t rows [7];
    dwrp_row_t r;
    logic clk = 1'b0, rst_n = 1'b0, warm_reset = 1'b0, avs_read = 1'b0, avs_write = 1'b0, req_valid = 1'b0;
    logic pci_attempt = 1'b0, pci_line_taken = 1'b0, pci_done = 1'b0, stall = 1'b0, give = 1'b0, clr = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, req_addr = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [1:0] req_cmd = 2'h0;
    logic [31:0] avs_readdata, up_addr, first_addr, q;
    logic avs_waitrequest, req_ready, up_valid, up_ready, up_single, up_line_ok, pci_retry, pci_reconnect;
    logic first_single;
    logic [7:0] nlines, bad;
    int failures = 0, checks = 0, cyc = 0;
    always #2 clk = !clk;
    dwrp_prefetch_ctrl dut_u (.*);
    dwrp_mem_model mem_u (.*);
    ////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict;
        end
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // Waits for waitrequest low; only the cycle timeout ends a hung wait
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task request(input logic [1:0] c, input logic [31:0] a);
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
    endtask
    task attempt(input logic ok, input string what);
        @(posedge clk) pci_attempt <= 1'b1;
        @(posedge clk) pci_attempt <= 1'b0;
        @(posedge clk);
        chk(what, {30'h0, pci_retry, pci_reconnect}, {30'h0, !ok, ok});
    endtask
    task give_line;
        @(posedge clk) give <= 1'b1;
        @(posedge clk) give <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task strobe(input logic [1:0] k);
        @(posedge clk);
        pci_line_taken <= k[0];
        pci_done <= k[1];
        @(posedge clk);
        pci_line_taken <= 1'b0;
        pci_done <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        // Line counts never above multiple counts in any row
        rows[0] = '{2'h1, 24'h00_0001, 24'h10_006d, 2'h1, 32'h1000_0044, 3'h2, 8'h04, 1'b0, 1'b0};
        rows[1] = '{2'h1, 24'h00_0025, 24'h10_006d, 2'h1, 32'h2000_0084, 3'h1, 8'h02, 1'b0, 1'b0};
        rows[2] = '{2'h0, 24'h00_0025, 24'h10_006d, 2'h1, 32'h1000_0084, 3'h1, 8'h02, 1'b0, 1'b0};
        rows[3] = '{2'h2, 24'h00_0001, 24'h03_0411, 2'h2, 32'h1000_0100, 3'h3, 8'h05, 1'b1, 1'b0};
        rows[4] = '{2'h1, 24'h00_0001, 24'h00_084b, 2'h0, 32'h1000_0208, 3'h1, 8'h03, 1'b1, 1'b0};
        rows[5] = '{2'h1, 24'h00_0001, 24'h00_0049, 2'h0, 32'h1000_030c, 3'h1, 8'h01, 1'b0, 1'b1};
        // Global enable clear: even a line read fetches only the requested word
        rows[6] = '{2'h1, 24'h00_0001, 24'h00_0048, 2'h1, 32'h1000_0404, 3'h1, 8'h01, 1'b0, 1'b1};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, `DWRP_OFS_RC1, 32'h0000_0000);
        chk("rc1 after reset", q, 32'h0000_0001);
        bus(1'b1, `DWRP_OFS_WIN_BASE, 32'h1000_0000);
        bus(1'b1, `DWRP_OFS_WIN_LIMIT, 32'h1000_ffff);
        stall <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            bus(1'b1, `DWRP_OFS_MODE, {30'h0, r.mode});
            bus(1'b1, `DWRP_OFS_RC1, {8'h00, r.rc1});
            bus(1'b1, `DWRP_OFS_RC2, {8'h00, r.rc2});
            @(posedge clk) clr <= 1'b1;
            @(posedge clk) clr <= 1'b0;
            request(r.cmd, r.addr);
            for (int n = 0; n < 100 && nlines < r.lines; n++) @(posedge clk);
            repeat (6) @(posedge clk);
            chk("line count", {24'h0, nlines}, {24'h0, r.lines});
            chk("first address", first_addr, r.single ? r.addr : {r.addr[31:6], 6'h00});
            chk("single fetch", {31'h0, first_single}, {31'h0, r.single});
            repeat (r.need - 3'h1) give_line;
            attempt(1'b0, "early attempt");
            give_line;
            attempt(1'b1, "reconnect");
            strobe(2'h1);
            chk("continued lines", {24'h0, nlines}, {24'h0, r.lines + {7'h0, r.ext}});
            strobe(2'h2);
            $display("row %0d done", i);
        end
        chk("line order", {24'h0, bad}, 32'h0000_0000);
        bus(1'b1, `DWRP_OFS_RC1, 32'h0000_0101);
        request(`DWRP_CMD_LINE, 32'h3000_0000);
        request(`DWRP_CMD_LINE, 32'h3000_0100);
        repeat (2) @(posedge clk);
        chk("ready at limit", {31'h0, req_ready}, 32'h0000_0000);
        strobe(2'h2);
        chk("ready after done", {31'h0, req_ready}, 32'h0000_0001);
        strobe(2'h2);
        $display("request limit done");
        bus(1'b1, `DWRP_OFS_RC2, 32'hffff_ffff);
        bus(1'b0, `DWRP_OFS_RC2, 32'h0000_0000);
        chk("rc2 writable", q, 32'h003f_ffff);
        @(posedge clk) warm_reset <= 1'b1;
        @(posedge clk) warm_reset <= 1'b0;
        bus(1'b0, `DWRP_OFS_RC2, 32'h0000_0000);
        chk("rc2 warm", q, 32'h0000_0001);
        bus(1'b0, `DWRP_OFS_RC1, 32'h0000_0000);
        chk("rc1 warm", q, 32'h0000_0001);
        bus(1'b1, `DWRP_OFS_MODE, 32'h0000_0000);
        bus(1'b1, `DWRP_OFS_RC2, 32'h00ff_ffff);
        bus(1'b0, `DWRP_OFS_RC2, 32'h0000_0000);
        chk("rc2 reserved", q, 32'h0000_0000);
        bus(1'b1, 8'h50, 32'h1234_5678);
        bus(1'b0, 8'h50, 32'h0000_0000);
        chk("unmapped", q, 32'h0000_0000);
        $display("register access done");
        // Hard reset mid-run must drop the window and the mode
        bus(1'b1, `DWRP_OFS_MODE, 32'h0000_0001);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, `DWRP_OFS_WIN_BASE, 32'h0000_0000);
        chk("base after reset", q, `DWRP_WIN_BASE_RESET);
        bus(1'b0, `DWRP_OFS_RC2, 32'h0000_0000);
        chk("rc2 hidden after reset", q, 32'h0000_0000);
        $display("hard reset done");
        print_verdict;
    end
endmodule // dwrp_prefetch_ctrl_tb_top
bind dwrp_prefetch_ctrl dwrp_prefetch_ctrl_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon_u (.*);
`default_nettype wire
